/* bench/scri_far_model.sv */
// far side model: tag srams, data srams and the agent
// assumes device strobes change on the mclk rising edge
`timescale 1ns/1ps
module scri_far_model (
	input wire logic mclk,
	input wire logic mute,
	input wire logic [3:0] gap,
	input wire logic tag_block_clear_n,
	input wire logic [1:0] cache_ram_write_en_n,
	input wire logic [15:0] cache_line_index,
	input wire logic tag_ram_chip_en_n,
	input wire logic tag_ram_output_en_n,
	input wire logic line_valid_o,
	input wire logic line_valid_oe,
	output logic data_ram_output_en_n,
	output logic tag_hit,
	output logic valid_val,
	output logic word_drv,
	output logic [1:0] word_val
);
	logic vld [0:65535];
	logic tog = 1'b0;
	int cnt = 0;
	initial begin
		foreach (vld[i]) begin
			vld[i] = 1'b0;
		end
		data_ram_output_en_n = 1'b1;
		word_drv = 1'b0;
		word_val = 2'h0;
	end
	assign tag_hit = vld[cache_line_index];
	assign valid_val = !tag_ram_output_en_n ? vld[cache_line_index] : tog;
	always @(posedge mclk) begin
		// released valid toggles so a stale level never passes
		tog <= ~tog;
		if (!tag_ram_chip_en_n && &cache_ram_write_en_n && !tag_hit &&
			!mute && cnt == 0) begin
			cnt <= 5 + gap;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		data_ram_output_en_n <= !(cnt >= 1 && cnt <= 4);
		word_drv <= cnt >= 1 && cnt <= 4;
		word_val <= (cnt >= 1 && cnt <= 4) ? 2'(4 - cnt) : ~word_val;
		if (!tag_ram_chip_en_n && !cache_ram_write_en_n[0] && line_valid_oe) begin
			vld[cache_line_index] <= line_valid_o;
		end
		if (!tag_block_clear_n) begin
			foreach (vld[i]) begin
				vld[i] <= 1'b0;
			end
		end
	end
endmodule

/* bench/test_secondary_cache_ram_interface.sv */
// bench for the secondary cache ram control block
// assumes the far model answers probes and refills on mclk
`timescale 1ns/1ps
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_secondary_cache_ram_interface;
	logic mclk = 1'b0, sys_rst = 1'b1, mode_load = 1'b0, req_valid = 1'b0;
	logic mute = 1'b0, doe_q = 1'b1, ce = 1'b1;
	logic [15:0] mode_bits = 16'h0000, req_line = 16'h0000, cur_line, idx;
	logic [1:0] req_op = 2'h0, req_word = 2'h0, cwe_n, dce_n, dw_o, dw_i;
	logic [1:0] w_val;
	logic [3:0] gap = 4'h0;
	logic [31:0] seed = 32'h0000_004e;
	logic req_ready, resp_done, resp_hit, resp_timeout, clr_n, tce_n, tde_n;
	logic toe_n, doe_n, tag_hit, dw_oe, v_o, v_oe, v_i, v_val, w_drv, sc_en;
	int fails = 0, cmp_count = 0, lat, lat_s;
	int we_cnt, clr_cnt, tce_cnt, tde_cnt, toe_cnt, dce_cnt;
	always #12.5 mclk = ~mclk;
	assign dw_i = dw_oe ? dw_o : w_val;
	assign v_i = v_oe ? v_o : v_val;
	scri_ctrl #(.DOE_WAIT(8)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
		.clk_en(ce), .mode_load(mode_load), .mode_bits(mode_bits),
		.req_valid(req_valid), .req_op(req_op), .req_line(req_line),
		.req_word(req_word), .req_ready(req_ready), .resp_done(resp_done),
		.resp_hit(resp_hit), .resp_timeout(resp_timeout),
		.tag_block_clear_n(clr_n), .cache_ram_write_en_n(cwe_n),
		.data_ram_chip_en_n(dce_n), .data_ram_output_en_n(doe_n),
		.cache_line_index(idx), .tag_hit(tag_hit), .tag_ram_chip_en_n(tce_n),
		.tag_latch_en_n(tde_n), .tag_ram_output_en_n(toe_n),
		.doubleword_index_i(dw_i), .doubleword_index_o(dw_o),
		.doubleword_index_oe(dw_oe), .line_valid_i(v_i), .line_valid_o(v_o),
		.line_valid_oe(v_oe), .sc_enabled(sc_en));
	scri_far_model far_u (.mclk(mclk), .mute(mute), .gap(gap),
		.tag_block_clear_n(clr_n), .cache_ram_write_en_n(cwe_n),
		.cache_line_index(idx), .tag_ram_chip_en_n(tce_n),
		.tag_ram_output_en_n(toe_n), .line_valid_o(v_o),
		.line_valid_oe(v_oe), .data_ram_output_en_n(doe_n),
		.tag_hit(tag_hit), .valid_val(v_val), .word_drv(w_drv),
		.word_val(w_val));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// a read miss refills four doublewords, a read hit moves no data in
	function automatic int beats(input logic [1:0] o, input logic hit);
		return (o == 2'h0 && !hit) ? 4 : 0;
	endfunction
	always @(negedge mclk) begin
		if (!sys_rst) begin
			`CK("we copies", cwe_n[1], cwe_n[0])
			`CK("dce copies", dce_n[1], dce_n[0])
			if (!tce_n) `CK("line", cur_line, idx)
			if (dw_oe) `CK("word", req_word, dw_o)
			if (w_drv) `CK("word clash", 1'b0, dw_oe)
			if (req_op == 2'h0 && !cwe_n[0] && tce_n) `CK("doe", 1'b0, doe_q)
			we_cnt += int'(!cwe_n[0] && tce_n);
			clr_cnt += int'(!clr_n);
			tce_cnt += int'(!tce_n);
			tde_cnt += int'(!tde_n);
			toe_cnt += int'(!toe_n);
			dce_cnt += int'(!dce_n[0]);
			doe_q = doe_n;
		end
	end
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic boot(input logic [15:0] bits);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		`CK("reset", 8'hfc, {clr_n, tce_n, tde_n, toe_n, cwe_n, dw_oe, v_oe})
		@(posedge mclk);
		sys_rst <= 1'b0;
		mode_bits <= bits;
		mode_load <= 1'b1;
		@(posedge mclk);
		mode_load <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task automatic run_op(input logic [1:0] o, input logic [15:0] l);
		int n;
		cur_line = l;
		{we_cnt, clr_cnt, tce_cnt, tde_cnt, toe_cnt, dce_cnt} = '0;
		seed = nxt(seed);
		@(posedge mclk);
		req_op <= o;
		req_line <= l;
		req_word <= seed[1:0];
		req_valid <= 1'b1;
		n = 0;
		do begin @(negedge mclk); n++; end while (req_ready !== 1'b1 && n < 50);
		@(posedge mclk);
		req_valid <= 1'b0;
		lat = 0;
		do begin @(negedge mclk); lat++; end while (resp_done !== 1'b1 && lat < 50);
		if (n >= 50 || lat >= 50) begin
			fails++;
			finish_test();
		end
		repeat (2) @(negedge mclk);
	endtask
	task automatic rd(input logic [15:0] l, input logic h);
		run_op(2'h0, l);
		`CK("hit", h, resp_hit)
		`CK("beats", beats(2'h0, h), we_cnt)
		`CK("tag probe", 1'b1, tce_cnt > 0)
		`CK("tag latch", 1'b1, tde_cnt > 0)
		`CK("tag read", 1'b1, toe_cnt > 0)
		`CK("data read", 1'b1, dce_cnt > 0)
	endtask
	initial begin
		logic [15:0] l;
		boot(16'h8000);
		`CK("enable off", 1'b0, sc_en)
		`CK("ready off", 1'b0, req_ready)
		boot(16'h9000);
		`CK("enable on", 1'b1, sc_en)
		// a mode load while the clock enable is low must be ignored
		@(posedge mclk);
		ce <= 1'b0;
		mode_bits <= 16'h0000;
		mode_load <= 1'b1;
		repeat (2) @(posedge mclk);
		ce <= 1'b1;
		mode_load <= 1'b0;
		@(negedge mclk);
		`CK("frozen mode", 1'b1, sc_en)
		`CK("frozen ready", 1'b1, req_ready)
		for (int i = 0; i < 6; i++) begin
			seed = nxt(seed);
			l = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed[15:0];
			gap <= 4'(seed[17:16] % 2'h3);
			rd(l, 1'b0);
			rd(l, 1'b1);
			lat_s = lat;
		end
		$display("test refill and hit done");
		run_op(2'h1, l);
		`CK("write strobe", 1'b1, we_cnt > 0)
		mute <= 1'b1;
		run_op(2'h2, l);
		mute <= 1'b0;
		rd(l, 1'b0);
		mute <= 1'b1;
		run_op(2'h3, l);
		`CK("clear cycles", 4, clr_cnt)
		mute <= 1'b0;
		rd(16'h0000, 1'b0);
		$display("test invalidate and clear done");
		mute <= 1'b1;
		run_op(2'h0, 16'h1234);
		`CK("timeout", 1'b1, resp_timeout)
		mute <= 1'b0;
		rd(16'h1234, 1'b0);
		`CK("timeout off", 1'b0, resp_timeout)
		$display("test timeout done");
		boot(16'h1000);
		rd(16'h4321, 1'b0);
		rd(16'h4321, 1'b1);
		`CK("dual deselect", lat_s + 1, lat)
		$display("test deselect style done");
		finish_test();
	end
endmodule

/* hw/scri_ctrl.sv */
// secondary cache ram control: strobes, line and word index, valid
// assumes external tag and data srams plus an agent, all on mclk
`timescale 1ns/1ps
`include "scri_defs.svh"
// Notes on behaviour
// - block clear output pulses low to invalidate all tag lines
// - nothing waits on block clear; lines are also invalidated singly
// - cache write enable goes low for every cache ram write
// - write enable and data chip enable come as two equal bit copies
// - data chip enable low makes data rams read the addressed word
// - refill write enable follows sampled data output enable
// - a 16-bit line index addresses tag and data rams
// - tag chip enable low starts probe, or write with write enable
// - tag latch enable captures tag for the later refill write
// - tag output enable low lets tag rams drive their contents
// - word index driven here on hits, by agent on refills
// - valid driven here to mark a line valid or invalid
// - interface used only when boot enable bit is one
// - boot bit picks dual or single cycle deselect rams
module scri_ctrl #(
	parameter int LINE_W = `SCRI_LINE_W,
	parameter int DOE_WAIT = `SCRI_DOE_WAIT_MAX
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic mode_load,
	input wire logic [`SCRI_MODE_W-1:0] mode_bits,
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [LINE_W-1:0] req_line,
	input wire logic [1:0] req_word,
	output logic req_ready,
	output logic resp_done,
	output logic resp_hit,
	output logic resp_timeout,
	output logic tag_block_clear_n,
	output logic [1:0] cache_ram_write_en_n,
	output logic [1:0] data_ram_chip_en_n,
	input wire logic data_ram_output_en_n,
	output logic [LINE_W-1:0] cache_line_index,
	input wire logic tag_hit,
	output logic tag_ram_chip_en_n,
	output logic tag_latch_en_n,
	output logic tag_ram_output_en_n,
	input wire logic [1:0] doubleword_index_i,
	output logic [1:0] doubleword_index_o,
	output logic doubleword_index_oe,
	input wire logic line_valid_i,
	output logic line_valid_o,
	output logic line_valid_oe,
	output logic sc_enabled
);
	// the wait counter is eight bits wide, so longer waits cannot be served
	if (LINE_W != `SCRI_LINE_W || DOE_WAIT < 1 || DOE_WAIT > 255) begin
		$error("scri_ctrl: unsupported parameters");
	end

	typedef struct packed {
		scri_pkg::scri_state_t st;
		scri_pkg::scri_op_t op;
		logic [LINE_W-1:0] line;
		logic [1:0] word;
		logic [7:0] cnt;
		logic [2:0] beats;
		logic ready;
		logic done;
		logic hit;
		logic tmo;
	} scri_ctl_t;
	scri_ctl_t st_q, st_d;

	// strobe vector: clr, cwe, dce, tce, tde, toe, word oe, valid oe, valid
	localparam int SW = 9;
	localparam logic [SW-1:0] S_IDLE = 9'h1f8;
	logic [SW-1:0] s_d, s_q;
	logic [LINE_W-1:0] line_q;
	logic [1:0] word_q;
	logic en, single_desel, doe_seen;

	scri_mode u_mode (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.mode_load(mode_load),
		.mode_bits(mode_bits),
		.sc_enabled(en),
		.single_desel(single_desel)
	);

	assign doe_seen = !data_ram_output_en_n;

	always_comb begin
		st_d = st_q;
		s_d = S_IDLE;
		if (clk_en) begin
			st_d.done = 1'b0;
			st_d.ready = 1'b0;
			unique case (st_q.st)
			scri_pkg::ST_IDLE: begin
				st_d.ready = en;
				if (req_valid && st_q.ready && en) begin
					st_d.ready = 1'b0;
					st_d.op = scri_pkg::scri_op_t'(req_op);
					st_d.line = req_line;
					st_d.word = req_word;
					st_d.cnt = 8'h00;
					st_d.hit = 1'b0;
					st_d.tmo = 1'b0;
					unique case (scri_pkg::scri_op_t'(req_op))
					scri_pkg::OP_CLEAR: st_d.st = scri_pkg::ST_CLEAR;
					scri_pkg::OP_INVAL: st_d.st = scri_pkg::ST_INVAL;
					default: st_d.st = scri_pkg::ST_PROBE;
					endcase
				end
			end
			scri_pkg::ST_CLEAR: begin
				s_d[8] = 1'b0;
				st_d.cnt = st_q.cnt + 8'h01;
				if (st_q.cnt == `SCRI_CLEAR_CYCLES - 8'h01) begin
					st_d.st = scri_pkg::ST_DESEL;
				end
			end
			scri_pkg::ST_PROBE: begin
				s_d[5] = 1'b0;
				// latch tag for a possible refill
				s_d[4] = 1'b0;
				s_d[6] = (st_q.op != scri_pkg::OP_READ);
				s_d[2] = 1'b1;
				st_d.st = scri_pkg::ST_CHECK;
			end
			scri_pkg::ST_CHECK: begin
				// tag rams drive valid and match
				s_d[3] = st_q.cnt[0];
				s_d[2] = 1'b1;
				st_d.cnt = st_q.cnt + 8'h01;
				// valid read from tag ram
				// sampled one cycle late: the output enable must be on the pins
				if (st_q.cnt[0]) begin
					st_d.cnt = 8'h00;
					st_d.hit = tag_hit && line_valid_i;
					if (tag_hit && line_valid_i) begin
						st_d.st = scri_pkg::ST_HIT;
					end else begin
						st_d.beats = 3'h0;
						st_d.st = scri_pkg::ST_REFILL;
					end
				end
			end
			scri_pkg::ST_HIT: begin
				s_d[2] = 1'b1;
				if (st_q.op == scri_pkg::OP_WRITE) begin
					s_d[7] = 1'b0;
					s_d[6] = 1'b0;
				end else begin
					s_d[6] = 1'b0;
				end
				st_d.st = scri_pkg::ST_DESEL;
			end
			scri_pkg::ST_REFILL: begin
				s_d[2] = 1'b0;
				s_d[6] = 1'b0;
				st_d.word = doubleword_index_i;
				st_d.cnt = st_q.cnt + 8'h01;
				// write paced by sampled output enable
				if (doe_seen) begin
					s_d[7] = 1'b0;
					st_d.cnt = 8'h00;
					st_d.beats = st_q.beats + 3'h1;
					if (st_q.beats == 3'(`SCRI_WORDS_PER_LINE - 1)) begin
						st_d.st = scri_pkg::ST_TAGWR;
					end
				end else if (st_q.cnt == 8'(DOE_WAIT - 1)) begin
					st_d.tmo = 1'b1;
					st_d.st = scri_pkg::ST_INVAL;
				end
			end
			scri_pkg::ST_TAGWR: begin
				s_d[5] = 1'b0;
				s_d[7] = 1'b0;
				s_d[1] = 1'b1;
				s_d[0] = 1'b1;
				st_d.st = scri_pkg::ST_DESEL;
			end
			scri_pkg::ST_INVAL: begin
				s_d[5] = 1'b0;
				s_d[7] = 1'b0;
				s_d[1] = 1'b1;
				s_d[0] = 1'b0;
				st_d.st = scri_pkg::ST_DESEL;
			end
			scri_pkg::ST_DESEL: begin
				// dual deselect adds an idle cycle
				st_d.cnt = st_q.cnt + 8'h01;
				if (single_desel || st_q.cnt[0]) begin
					st_d.done = 1'b1;
					st_d.cnt = 8'h00;
					st_d.st = scri_pkg::ST_IDLE;
				end
			end
			default: st_d.st = scri_pkg::ST_IDLE;
			endcase
			if (st_q.st == scri_pkg::ST_CLEAR && st_d.st == scri_pkg::ST_DESEL)
				st_d.cnt = 8'h00;
		end else begin
			s_d = s_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '{st: scri_pkg::ST_IDLE, op: scri_pkg::OP_READ,
				default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	scri_outreg #(.W(SW), .RST(S_IDLE)) u_strobe (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.d(s_d),
		.q(s_q)
	);

	scri_outreg #(.W(LINE_W + 2), .RST('0)) u_addr (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.d({st_d.line, st_d.word}),
		.q({line_q, word_q})
	);

	assign cache_ram_write_en_n = {2{s_q[7]}};
	assign data_ram_chip_en_n = {2{s_q[6]}};
	assign tag_block_clear_n = s_q[8];
	assign tag_ram_chip_en_n = s_q[5];
	assign tag_latch_en_n = s_q[4];
	assign tag_ram_output_en_n = s_q[3];
	assign doubleword_index_oe = s_q[2];
	assign line_valid_oe = s_q[1];
	assign line_valid_o = s_q[0];
	assign cache_line_index = line_q;
	assign doubleword_index_o = word_q;
	assign req_ready = st_q.ready;
	assign resp_done = st_q.done;
	assign resp_hit = st_q.hit;
	assign resp_timeout = st_q.tmo;
	assign sc_enabled = en;

	copies_equal_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cache_ram_write_en_n[0] == cache_ram_write_en_n[1]
		&& data_ram_chip_en_n[0] == data_ram_chip_en_n[1])
		else $error("strobe copies differ");
	tce_excl_oe_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!tag_ram_chip_en_n |-> tag_ram_output_en_n)
		else $error("tag enable with tag output enable");
	disabled_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!sc_enabled && $past(!sc_enabled) && st_q.st == scri_pkg::ST_IDLE
		|=> tag_ram_chip_en_n && tag_block_clear_n)
		else $error("access while disabled");
	refill_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && st_q.st == scri_pkg::ST_REFILL && !data_ram_output_en_n
		|=> !cache_ram_write_en_n[0])
		else $error("refill write not after doe");
	refill_nowrite_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && st_q.st == scri_pkg::ST_REFILL && data_ram_output_en_n
		|=> cache_ram_write_en_n[0])
		else $error("refill write without doe");
	word_owner_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && st_q.st == scri_pkg::ST_REFILL |=> !doubleword_index_oe)
		else $error("word driven during refill");
	clear_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(tag_block_clear_n) && clk_en |-> (!tag_block_clear_n)[*4])
		else $error("clear pulse short");
	tag_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!tag_latch_en_n |-> !tag_ram_chip_en_n)
		else $error("tag latch without probe");
	valid_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
		line_valid_oe |-> !tag_ram_chip_en_n && !cache_ram_write_en_n[0])
		else $error("valid driven outside tag write");
	hit_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && st_q.st == scri_pkg::ST_HIT |=> !data_ram_chip_en_n[0])
		else $error("no data read on hit");
endmodule

/* hw/scri_mode.sv */
// boot mode capture: takes enable and deselect style after reset release
// assumes mode_bits stable while mode_load pulses
`timescale 1ns/1ps
`include "scri_defs.svh"
module scri_mode (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic mode_load,
	input wire logic [`SCRI_MODE_W-1:0] mode_bits,
	output logic sc_enabled,
	output logic single_desel
);
	typedef struct packed {
		logic en;
		logic sd;
	} scri_md_t;
	scri_md_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (clk_en && mode_load) begin
			st_d.en = mode_bits[`SCRI_MODE_SC_EN_BIT];
			st_d.sd = mode_bits[`SCRI_MODE_SINGLE_DESEL_BIT];
		end
	end

	// reset holds the cache disabled until the strap is loaded
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '{en: 1'b0, sd: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign sc_enabled = st_q.en;
	assign single_desel = st_q.sd;
endmodule

/* hw/scri_outreg.sv */
// output flop stage: every ram strobe leaves through a register
// assumes one clock, synchronous reset, clock enable
`timescale 1ns/1ps
`include "scri_defs.svh"
module scri_outreg #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] v;
	} scri_or_t;
	scri_or_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (clk_en) begin
			st_d.v = d;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '{v: RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.v;
endmodule

/* include/scri_defs.svh */
// constant macros for the secondary cache ram interface
// assumes inclusion by bare name from the include folder
`ifndef SCRI_DEFS_SVH
`define SCRI_DEFS_SVH
`define SCRI_LINE_W 16
`define SCRI_TAG_W 20
`define SCRI_MODE_SC_EN_BIT 12
`define SCRI_MODE_SINGLE_DESEL_BIT 15
`define SCRI_MODE_W 16
`define SCRI_WORDS_PER_LINE 4
`define SCRI_DOE_WAIT_MAX 8'h40
`define SCRI_CLEAR_CYCLES 8'h04
`endif

/* include/scri_pkg.sv */
// types for the secondary cache ram interface
// assumes the defs header holds all numbers
package scri_pkg;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_CLEAR = 9'h002,
		ST_PROBE = 9'h004,
		ST_CHECK = 9'h008,
		ST_HIT = 9'h010,
		ST_REFILL = 9'h020,
		ST_TAGWR = 9'h040,
		ST_INVAL = 9'h080,
		ST_DESEL = 9'h100
	} scri_state_t;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_INVAL = 2'h2,
		OP_CLEAR = 2'h3
	} scri_op_t;
endpackage
